/* hdl/spims_pkg.sv */
/*
 * Package for the SPI master/slave block: mode encodings, the control
 * and status structs carried on the block's ports, and timing figures.
 * Assumes a single 40 MHz clock domain and a synchronous reset.
 */
package spims_pkg;

    // clock rate, bits per byte, bit counter width and the count that ends a byte
    localparam int unsigned SPIMS_CLK_HZ      = 40_000_000;
    localparam int unsigned SPIMS_BITS        = 8;
    localparam int unsigned SPIMS_CNT_W       = 4;
    localparam logic [3:0]  SPIMS_LAST_BIT    = 4'h8;

    // bit-order field position in the packed configuration word, and the reset value of the data registers
    localparam int unsigned SPIMS_LSB_FIRST_POS = 7;
    localparam logic [7:0]  SPIMS_DATA_RST      = 8'h00;

    typedef enum logic [1:0] {
        SPIMS_MODE0 = 2'h0,
        SPIMS_MODE1 = 2'h1,
        SPIMS_MODE2 = 2'h2,
        SPIMS_MODE3 = 2'h3
    } spims_mode_t;

    typedef struct packed {
        logic        lsb_first;      // bit-order control
        logic        enable;         // block enable
        logic        slave_mode;     // 1: serial_slave_mode, 0: serial_master_mode
        logic        cpol;           // clock polarity
        logic        cpha;           // clock phase
        logic        aux_en;         // firmware-driven slave select
        logic        aux_sel0;       // select value when aux_en is set
    } spims_cfg_t;

    typedef struct packed {
        logic        tx_empty;
        logic        rx_full;
        logic        complete;
        logic        overrun;
    } spims_status_t;

    // serial line group
    typedef struct packed {
        logic        sclk;
        logic        mosi;
        logic        ss_n;
    } spims_pins_in_t;

endpackage : spims_pkg

/* hdl/spims_shifter.sv */
/*
 * Eight-bit shift register with parallel load, left or right shifting.
 * Assumes the caller gives at most one of load and shift per cycle.
 */
module spims_shifter
    import spims_pkg::*;
#(
    parameter int unsigned WIDTH = 8
) (
    // clock and reset
    input  wire logic             clk_i,
    input  wire logic             resetn_i,
    // control
    input  wire logic             load_i,
    input  wire logic [WIDTH-1:0] load_data_i,
    input  wire logic             shift_i,
    input  wire logic             lsb_first_i,
    input  wire logic             serial_i,
    // state
    output logic      [WIDTH-1:0] data_o
);

    logic [WIDTH-1:0] shift_register_reg;
    logic [WIDTH-1:0] shift_register_next;

    always_comb begin
        shift_register_next = shift_register_reg;
        if (load_i) begin
            shift_register_next = load_data_i;
        end else if (shift_i) begin
            if (lsb_first_i) begin
                shift_register_next = {serial_i, shift_register_reg[WIDTH-1:1]};
            end else begin
                shift_register_next = {shift_register_reg[WIDTH-2:0], serial_i};
            end
        end
    end

    // data registers are kept across a block disable, only the chip reset clears them
    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            shift_register_reg <= '0;
        end else begin
            shift_register_reg <= shift_register_next;
        end
    end

    assign data_o = shift_register_reg;

endmodule // spims_shifter

/* hdl/spims_core.sv */
/*
 * SPI block that runs as master (serial clock from clk_i divided by four)
 * or as slave (serial clock and select sampled from the pins on clk_i).
 * Assumes slave pin inputs are synchronous to clk_i and much slower.
 */
module spims_core
    import spims_pkg::*;
(
    // clock and reset
    input  wire logic          clk_i,
    input  wire logic          resetn_i,
    // configuration and firmware access
    input  wire spims_cfg_t    cfg_i,
    input  wire logic          tx_write_i,
    input  wire logic [7:0]    tx_data_i,
    input  wire logic          rx_read_i,
    input  wire logic          status_read_i,
    // serial pins
    input  wire spims_pins_in_t pins_i,
    output logic               data_out_o,
    output logic               aux_out_o,
    output logic               aux_oe_o,
    // firmware-visible state
    output logic [7:0]         rx_data_o,
    output spims_status_t      status_o,
    output logic               irq_tx_o,
    output logic               busy_o
);

    typedef enum logic [2:0] {
        SPIMS_IDLE  = 3'b001,
        SPIMS_LEAD  = 3'b010,
        SPIMS_TRAIL = 3'b100
    } spims_state_t;

    function automatic logic pick_bit(input logic [7:0] d, input logic lsb);
        return lsb ? d[0] : d[7];
    endfunction

    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic lsb, input logic b);
        return lsb ? {b, d[7:1]} : {d[6:0], b};
    endfunction

    spims_state_t  state_reg, state_next;
    logic [3:0]    cnt_reg, cnt_next;
    logic          div_reg, div_next;
    logic          sclk_reg, sclk_next;
    logic          dout_reg, dout_next;
    logic          aux_oe_reg, aux_oe_next;
    logic [7:0]    transmit_buffer_reg, transmit_buffer_next;
    logic [7:0]    receive_buffer_reg, receive_buffer_next;
    logic          tx_empty_reg, tx_empty_next;
    logic          rx_full_reg, rx_full_next;
    logic          cmpl_reg, cmpl_next;
    logic          ovr_reg, ovr_next;
    logic          armed_reg, armed_next;
    logic          irq_reg, irq_next;
    logic          sample_reg, sample_next;
    logic          ss_d_reg, ss_d_next;
    logic          sck_d_reg, sck_d_next;
    logic          slv_inprog_reg, slv_inprog_next;
    logic          sh_full_reg, sh_full_next;
    logic          busy_reg, busy_next;
    logic          sh_load, sh_shift;
    logic [7:0]    sh_data;

    logic          master, slave, sel, lead_edge, trail_edge, sck_lvl;
    logic          rx_evt, done_evt, lead_act, trail_act;

    spims_shifter #(.WIDTH(SPIMS_BITS)) u_shift (
        .clk_i       (clk_i),
        .resetn_i    (resetn_i),
        .load_i      (sh_load),
        .load_data_i (transmit_buffer_reg),
        .shift_i     (sh_shift),
        .lsb_first_i (cfg_i.lsb_first),
        .serial_i    (sample_reg),
        .data_o      (sh_data)
    );

    always_comb begin
        master     = cfg_i.enable && !cfg_i.slave_mode;
        slave      = cfg_i.enable && cfg_i.slave_mode;
        sel        = cfg_i.aux_en ? !cfg_i.aux_sel0 : !pins_i.ss_n;
        // slave pin edges, normalised so that 1 is the active clock phase
        sck_lvl    = pins_i.sclk ^ cfg_i.cpol;
        lead_edge  = slave && sel && sck_lvl && !sck_d_reg;
        trail_edge = slave && sel && !sck_lvl && sck_d_reg;
        state_next = state_reg;
        cnt_next   = cnt_reg;
        div_next   = div_reg;
        sclk_next  = cfg_i.cpol;
        dout_next  = 1'b1;
        aux_oe_next = master;
        transmit_buffer_next = tx_write_i ? tx_data_i : transmit_buffer_reg;
        receive_buffer_next  = receive_buffer_reg;
        tx_empty_next = tx_empty_reg;
        rx_full_next  = rx_full_reg && !rx_read_i;
        cmpl_next     = cmpl_reg && !status_read_i;
        ovr_next      = ovr_reg && !status_read_i;
        armed_next    = armed_reg;
        sample_next   = sample_reg;
        ss_d_next     = sel;
        sck_d_next    = sck_lvl;
        slv_inprog_next = slv_inprog_reg;
        sh_full_next  = sh_full_reg;
        sh_load       = 1'b0;
        sh_shift      = 1'b0;
        rx_evt        = 1'b0;
        done_evt      = 1'b0;
        lead_act      = 1'b0;
        trail_act     = 1'b0;
        if (tx_write_i) begin
            tx_empty_next = 1'b0;
        end
        if (!cfg_i.enable) begin
            // block disable clears control and status, data registers stay
            state_next = SPIMS_IDLE;
            cnt_next   = '0;
            div_next   = 1'b0;
            tx_empty_next = 1'b1;
            rx_full_next = 1'b0;
            cmpl_next  = 1'b0;
            ovr_next   = 1'b0;
            armed_next = 1'b0;
            slv_inprog_next = 1'b0;
            sh_full_next = 1'b0;
            sck_d_next = 1'b0;
            if (!cfg_i.slave_mode) begin
                dout_next = pick_bit(sh_data, cfg_i.lsb_first);
            end
        end else if (master) begin
            div_next = !div_reg;
            dout_next = dout_reg;
            sclk_next = sclk_reg;
            if (state_reg == SPIMS_IDLE) begin
                dout_next = pick_bit(sh_data, cfg_i.lsb_first);
                sclk_next = cfg_i.cpol;
            end
            if (div_reg) begin
                unique case (state_reg)
                    SPIMS_IDLE: begin
                        if (!tx_empty_reg) begin
                            sh_load = 1'b1;
                            tx_empty_next = !tx_write_i;
                            armed_next = 1'b1;
                            cnt_next = '0;
                            state_next = SPIMS_LEAD;
                            dout_next = pick_bit(transmit_buffer_reg, cfg_i.lsb_first);
                        end
                    end
                    SPIMS_LEAD: begin
                        sclk_next = !cfg_i.cpol;
                        lead_act = 1'b1;
                        state_next = SPIMS_TRAIL;
                    end
                    SPIMS_TRAIL: begin
                        sclk_next = cfg_i.cpol;
                        trail_act = 1'b1;
                        state_next = SPIMS_LEAD;
                        // phase 1 takes its eighth sample on this trailing edge
                        if (cnt_reg == SPIMS_LAST_BIT - 4'(cfg_i.cpha)) begin
                            state_next = SPIMS_IDLE;
                            done_evt = !cfg_i.cpha;
                            if (!tx_empty_reg) begin
                                // back-to-back byte, loaded on the closing edge
                                sh_load = 1'b1;
                                tx_empty_next = !tx_write_i;
                                cnt_next = '0;
                                state_next = SPIMS_LEAD;
                                dout_next = pick_bit(transmit_buffer_reg, cfg_i.lsb_first);
                            end
                        end
                    end
                endcase
            end
        end else begin
            // slave: a negated select resets the bit count and in-progress flag; loaded data and status stay
            if (!sel) begin
                state_next = SPIMS_IDLE;
                cnt_next = '0;
                slv_inprog_next = 1'b0;
                sck_d_next = 1'b0;
            end else begin
                if (!slv_inprog_reg && !sh_full_reg && !tx_empty_reg) begin
                    sh_load = 1'b1;
                    sh_full_next = 1'b1;
                    tx_empty_next = !tx_write_i;
                    armed_next = 1'b1;
                end
                if (!cfg_i.cpha && sel && !ss_d_reg) begin
                    slv_inprog_next = 1'b1;
                end
                if (lead_edge) begin
                    slv_inprog_next = 1'b1;
                    lead_act = 1'b1;
                end
                trail_act = trail_edge;
                dout_next = pick_bit(sh_data, cfg_i.lsb_first);
            end
        end
        // phase selects which edge samples and which shifts
        if ((lead_act && !cfg_i.cpha) || (trail_act && cfg_i.cpha)) begin
            sample_next = pins_i.mosi;
            cnt_next = cnt_reg + 4'h1;
            if (cnt_reg == SPIMS_LAST_BIT - 4'h1) begin
                rx_evt = 1'b1;
            end
        end
        if (((trail_act && !cfg_i.cpha) || (lead_act && cfg_i.cpha && cnt_reg != '0)) && !sh_load) begin
            // the pin shows the next bit on the same edge as the shift
            sh_shift  = 1'b1;
            dout_next = pick_bit(shift_in(sh_data, cfg_i.lsb_first, sample_reg), cfg_i.lsb_first);
        end
        if (rx_evt) begin
            ovr_next = ovr_next || rx_full_reg || (rx_full_reg && rx_read_i);
            rx_full_next = 1'b1;
            // the eighth bit joins the seven already shifted in
            receive_buffer_next = shift_in(sh_data, cfg_i.lsb_first, pins_i.mosi);
            if (cfg_i.cpha) begin
                done_evt = 1'b1;
            end
            if (slave) begin
                slv_inprog_next = 1'b0;
                sh_full_next = 1'b0;
                cnt_next = '0;
            end
        end
        if (slave && !cfg_i.cpha && trail_act && cnt_reg == '0 && sck_d_reg) begin
            done_evt = 1'b1;
        end
        // a back-to-back load restarts the bit count
        if (master && sh_load) begin
            cnt_next = '0;
        end
        busy_next = (state_next != SPIMS_IDLE) || slv_inprog_next;
        if (done_evt) begin
            cmpl_next = 1'b1;
        end
        irq_next = armed_next && tx_empty_next;
    end

    always_ff @(posedge clk_i) begin
        if (!resetn_i) begin
            state_reg  <= SPIMS_IDLE;
            cnt_reg    <= '0;
            div_reg    <= 1'b0;
            sclk_reg   <= 1'b0;
            dout_reg   <= 1'b1;
            aux_oe_reg <= 1'b0;
            transmit_buffer_reg <= SPIMS_DATA_RST;
            receive_buffer_reg  <= SPIMS_DATA_RST;
            tx_empty_reg <= 1'b1;
            rx_full_reg  <= 1'b0;
            cmpl_reg   <= 1'b0;
            ovr_reg    <= 1'b0;
            armed_reg  <= 1'b0;
            irq_reg    <= 1'b0;
            sample_reg <= 1'b0;
            ss_d_reg   <= 1'b0;
            sck_d_reg  <= 1'b0;
            slv_inprog_reg <= 1'b0;
            sh_full_reg <= 1'b0;
            busy_reg   <= 1'b0;
        end else begin
            state_reg  <= state_next;
            cnt_reg    <= cnt_next;
            div_reg    <= div_next;
            sclk_reg   <= sclk_next;
            dout_reg   <= dout_next;
            aux_oe_reg <= aux_oe_next;
            transmit_buffer_reg <= transmit_buffer_next;
            receive_buffer_reg  <= receive_buffer_next;
            tx_empty_reg <= tx_empty_next;
            rx_full_reg  <= rx_full_next;
            cmpl_reg   <= cmpl_next;
            ovr_reg    <= ovr_next;
            armed_reg  <= armed_next;
            irq_reg    <= irq_next;
            sample_reg <= sample_next;
            ss_d_reg   <= ss_d_next;
            sck_d_reg  <= sck_d_next;
            slv_inprog_reg <= slv_inprog_next;
            sh_full_reg <= sh_full_next;
            busy_reg   <= busy_next;
        end
    end

    assign data_out_o = dout_reg;
    assign aux_out_o  = sclk_reg;
    assign aux_oe_o   = aux_oe_reg;
    assign rx_data_o  = receive_buffer_reg;
    assign status_o   = '{tx_empty: tx_empty_reg, rx_full: rx_full_reg, complete: cmpl_reg, overrun: ovr_reg};
    assign irq_tx_o   = irq_reg;
    assign busy_o     = busy_reg;

endmodule // spims_core

/* sim/spims_core_props.sv */
/* concurrent checks on the spims_core ports.
   assumes one clock and a synchronous active-low reset; bound below. */
module spims_core_props
    import spims_pkg::*;
(
    // clock and reset
    input wire logic           clk_i,
    input wire logic           resetn_i,
    // inputs
    input wire spims_cfg_t     cfg_i,
    input wire logic           tx_write_i,
    input wire logic           rx_read_i,
    input wire logic           status_read_i,
    input wire spims_pins_in_t pins_i,
    // outputs
    input wire logic           data_out_o,
    input wire logic           aux_out_o,
    input wire logic           aux_oe_o,
    input wire spims_status_t  status_o,
    input wire logic           busy_o
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!resetn_i);
    logic m_on;
    logic s_quiet;
    assign m_on    = cfg_i.enable && !cfg_i.slave_mode;
    assign s_quiet = cfg_i.slave_mode && (!cfg_i.enable || (cfg_i.aux_en ? cfg_i.aux_sel0 : pins_i.ss_n));

    a_clk_idle: assert property ($past(resetn_i) && $stable(cfg_i) && !cfg_i.slave_mode && !busy_o
        && !$past(busy_o) |-> aux_out_o == cfg_i.cpol) else $error("clock off idle level");
    a_aux_drive: assert property ($past(resetn_i) && $stable(cfg_i) |-> aux_oe_o == m_on)
        else $error("aux enable wrong");
    a_slave_quiet: assert property (s_quiet && $past(s_quiet) |-> data_out_o)
        else $error("slave output not idle high");
    a_txe_clear: assert property (cfg_i.enable && tx_write_i && status_o.tx_empty |=> !status_o.tx_empty)
        else $error("empty flag kept after write");
    a_txe_reload: assert property ($past(resetn_i) && m_on && $stable(cfg_i) && !busy_o && !status_o.tx_empty
        |-> ##[1:4] status_o.tx_empty) else $error("idle write not loaded");
    a_ovr_cause: assert property ($rose(status_o.overrun) |-> $past(status_o.rx_full))
        else $error("overrun without full");
    a_full_hold: assert property (status_o.rx_full && !rx_read_i && cfg_i.enable |=> status_o.rx_full)
        else $error("full dropped");
    a_full_clear: assert property (rx_read_i && !busy_o |=> !status_o.rx_full)
        else $error("full kept after read");
    a_cmpl_follow: assert property (m_on && $rose(status_o.rx_full) && !status_o.complete
        |-> ##[0:4] status_o.complete) else $error("complete late");
    a_stat_clear: assert property (status_read_i && !busy_o |=> !status_o.complete && !status_o.overrun)
        else $error("status read kept flags");
    a_off_clear: assert property (!cfg_i.enable && $past(!cfg_i.enable)
        |-> !status_o.rx_full && !status_o.complete && !status_o.overrun) else $error("flags kept off");
    c_master: cover property (m_on && $rose(status_o.complete));
    c_slave: cover property (cfg_i.slave_mode && $rose(status_o.rx_full));
    c_overrun: cover property ($rose(status_o.overrun));
endmodule // spims_core_props

bind spims_core spims_core_props props_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg_i), .tx_write_i(tx_write_i), .rx_read_i(rx_read_i),
    .status_read_i(status_read_i), .pins_i(pins_i), .data_out_o(data_out_o), .aux_out_o(aux_out_o),
    .aux_oe_o(aux_oe_o), .status_o(status_o), .busy_o(busy_o)
);

/* sim/spims_peer.sv */
/* far side of the link: a slave while the block is master, a master (xfer task)
   while the block is a slave. assumes pins sampled on clk_i, half bits of 2+ cycles. */
module spims_peer
    import spims_pkg::*;
(
    // clock and link setup
    input  wire logic       clk_i,
    input  wire logic       en_i,
    input  wire logic       dut_slave_i,
    input  wire logic       cpol_i,
    input  wire logic       cpha_i,
    input  wire logic       lsb_first_i,
    // slave role data
    input  wire logic [7:0] reply_i,
    output logic      [7:0] got_o,
    // link lines
    input  wire logic       dut_data_i,
    input  wire logic       dut_sclk_i,
    output spims_pins_in_t  pins_o
);
    timeunit 1ns;
    timeprecision 1ps;
    localparam int HALF = 4;
    logic       sclk_q = 1'b0, m_sclk = 1'b0, m_mosi = 1'b0, m_ss_n = 1'b1;
    logic [2:0] lead_n = 3'h0, trail_n = 3'h0, idx;
    logic [7:0] sh = 8'h00, nxt;
    logic       lead, trail, samp;
    assign lead   = (sclk_q == cpol_i) && (dut_sclk_i != cpol_i);
    assign trail  = (sclk_q != cpol_i) && (dut_sclk_i == cpol_i);
    assign samp   = cpha_i ? trail : lead;
    assign idx    = cpha_i ? lead_n - 3'h1 : trail_n;
    assign nxt    = lsb_first_i ? {dut_data_i, sh[7:1]} : {sh[6:0], dut_data_i};
    assign pins_o = dut_slave_i ? spims_pins_in_t'{m_ss_n ? cpol_i : m_sclk, m_mosi, m_ss_n}
                                : spims_pins_in_t'{cpol_i, reply_i[lsb_first_i ? idx : 3'h7 - idx], 1'b1};
    always @(posedge clk_i) begin
        sclk_q <= dut_sclk_i;
        if (dut_slave_i || !en_i) begin
            lead_n  <= 3'h0;
            trail_n <= 3'h0;
        end else begin
            lead_n  <= lead_n + 3'(lead);
            trail_n <= trail_n + 3'(trail);
            if (samp) begin
                sh <= nxt;
                if ((cpha_i ? trail_n : lead_n) == 3'h7) got_o <= nxt;
            end
        end
    end
    task automatic half();
        repeat (HALF) @(posedge clk_i);
        #2;
    endtask
    // one byte framed by the select line; drive and sample per clock phase
    task automatic xfer(input logic [7:0] d, output logic [7:0] r);
        int i;
        int k;
        r = 8'h00;
        m_sclk = cpol_i;
        m_ss_n = 1'b0;
        for (i = 0; i < 8; i++) begin
            k = lsb_first_i ? i : 7 - i;
            if (!cpha_i) m_mosi = d[k];
            half();
            m_sclk = ~cpol_i;
            if (cpha_i) m_mosi = d[k];
            else r[k] = dut_data_i;
            half();
            m_sclk = cpol_i;
            if (cpha_i) r[k] = dut_data_i;
        end
        half();
        m_ss_n = 1'b1;
        m_mosi = ~m_mosi;
    endtask
endmodule // spims_peer

/* sim/spims_core_test.sv */
/* self-checking bench for spims_core against spims_peer.
   assumes spims_pkg and the bound checker. */
`define CHK(act, exp) begin n_checks++; if ((act) !== (exp)) begin num_errors++; $display("BAD %0t got %h want %h", $time, act, exp); end end
module spims_core_test
    import spims_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic           clk_i;
    logic           resetn_i = 1'b0, tx_write = 1'b0, rx_read = 1'b0, status_read = 1'b0, auto_read = 1'b1;
    spims_cfg_t     cfg      = '0;
    logic [7:0]     tx_data  = 8'h00, reply = 8'h00, rx_data, got, q, a, b, popped;
    spims_pins_in_t pins;
    spims_status_t  status;
    logic           data_out, aux_out, aux_oe, irq_tx, busy;
    logic [7:0]     exp_q[$];
    int             num_errors = 0, n_checks = 0, cyc = 0, m;

    spims_core dut_u (
        .clk_i(clk_i), .resetn_i(resetn_i), .cfg_i(cfg), .tx_write_i(tx_write), .tx_data_i(tx_data),
        .rx_read_i(rx_read), .status_read_i(status_read), .pins_i(pins), .data_out_o(data_out),
        .aux_out_o(aux_out), .aux_oe_o(aux_oe), .rx_data_o(rx_data), .status_o(status), .irq_tx_o(irq_tx),
        .busy_o(busy)
    );
    spims_peer peer_u (
        .clk_i(clk_i), .en_i(cfg.enable), .dut_slave_i(cfg.slave_mode), .cpol_i(cfg.cpol), .cpha_i(cfg.cpha),
        .lsb_first_i(cfg.lsb_first), .reply_i(reply), .got_o(got), .dut_data_i(data_out), .dut_sclk_i(aux_out),
        .pins_o(pins)
    );

    initial begin
        clk_i = 1'b0;
        forever #12.5 clk_i = ~clk_i;
    end
    always @(posedge clk_i) begin
        cyc++;
        if (cyc == 50000) begin
            num_errors++;
            conclude();
        end
    end
    // each arriving receive byte is compared against the oldest note while any note is queued
    initial forever begin
        @(posedge clk_i);
        #1;
        if (status.rx_full === 1'b1 && exp_q.size() > 0) begin
            popped = exp_q.pop_front();
            `CHK(rx_data, popped)
            if (auto_read) begin
                #1 rx_read = 1'b1;
                @(posedge clk_i);
                #2 rx_read = 1'b0;
            end
        end
    end

    task automatic conclude();
        $display("checks %0d mismatches %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #2;
    endtask
    // mode changes happen while disabled so the clock never glitches
    task automatic set_cfg(input spims_cfg_t c);
        spims_cfg_t off;
        off = c;
        off.enable = 1'b0;
        cfg.enable = 1'b0;
        tick(2);
        cfg = off;
        tick(2);
        cfg = c;
        tick(2);
        `CHK(status.tx_empty, 1'b1)
        `CHK(irq_tx, 1'b0)
        `CHK(aux_oe, !c.slave_mode)
    endtask
    task automatic wr(input logic [7:0] d);
        tx_data = d;
        tx_write = 1'b1;
        tick(1);
        tx_write = 1'b0;
        `CHK(status.tx_empty, 1'b0)
    endtask
    task automatic wait_bit(input int sel, input logic clr);
        int k;
        for (k = 0; k < 400 && status[sel] !== 1'b1; k++) tick(1);
        `CHK(status[sel], 1'b1)
        if (clr) begin
            status_read = 1'b1;
            tick(1);
            status_read = 1'b0;
        end
    endtask
    task automatic mbyte(input logic [7:0] x, input logic [7:0] y);
        reply = y;
        exp_q.push_back(y);
        wr(x);
        wait_bit(1, 1'b1);
        `CHK(got, x)
    endtask
    task automatic sbyte(input logic [7:0] x, input logic [7:0] y, input logic sel);
        if (sel) begin
            wr(x);
            exp_q.push_back(y);
        end
        peer_u.xfer(y, q);
        `CHK(q, sel ? x : 8'hff)
        `CHK(status.rx_full, 1'b0)
        if (sel) wait_bit(1, 1'b1);
    endtask

    initial begin
        void'($urandom(32'h59ba0e0c));
        tick(4);
        resetn_i = 1'b1;
        for (m = 0; m < 4; m++) begin
            set_cfg('{1'($urandom), 1'b1, 1'b0, m[1], m[0], 1'b0, 1'b0});
            mbyte(8'($urandom), 8'($urandom));
            `CHK(irq_tx, 1'b1)
            `CHK(aux_out, cfg.cpol)
            $display("master mode %0d done", m);
        end
        a = 8'($urandom);
        reply = 8'($urandom);
        exp_q.push_back(reply);
        exp_q.push_back(reply);
        wr(a);
        for (m = 0; m < 20 && status.tx_empty !== 1'b1; m++) tick(1);
        wr(~a);
        wait_bit(1, 1'b1);
        `CHK(busy, 1'b1)
        wait_bit(1, 1'b1);
        `CHK(got, ~a)
        $display("chained bytes done");
        auto_read = 1'b0;
        mbyte(8'h00, 8'h3c);
        reply = 8'hc3;
        wr(8'hff);
        wait_bit(0, 1'b0);
        `CHK(status.rx_full, 1'b1)
        status_read = 1'b1;
        tick(1);
        status_read = 1'b0;
        `CHK(status.overrun, 1'b0)
        cfg.enable = 1'b0;
        tick(2);
        `CHK(status[2:0], 3'h0)
        `CHK(aux_out, cfg.cpol)
        auto_read = 1'b1;
        $display("overrun and disable done");
        for (m = 0; m < 4; m++) begin
            set_cfg('{1'($urandom), 1'b1, 1'b1, m[1], m[0], 1'b0, 1'b0});
            sbyte(8'($urandom), 8'($urandom), 1'b1);
            $display("slave mode %0d done", m);
        end
        set_cfg('{1'b0, 1'b1, 1'b1, 1'b0, 1'b0, 1'b1, 1'b0});
        b = 8'($urandom);
        sbyte(8'h96, b, 1'b1);
        cfg.aux_sel0 = 1'b1;
        sbyte(8'h00, 8'ha5, 1'b0);
        cfg.enable = 1'b0;
        tick(2);
        `CHK(data_out, 1'b1)
        `CHK(rx_data, b)
        $display("firmware select done");
        `CHK(exp_q.size(), 0)
        conclude();
    end
endmodule // spims_core_test
